// ==== mic_conditioner.v ====
// multi-function input conditioner: terminal polarity, debounce and function decode
//
// Contract
// - function 15 active requests PID disabled
// - function 16 active stops output, coasting; next change requests restart from 0Hz
// - function 17 active blocks all parameter writes
// - function 18: on selects external terminals, off uses configured source
// - function 19: on selects keypad, off uses configured source
// - function 20: on selects communication, off uses configured source
// - function 21 sets direction with top priority if both directions allowed
// - function 22: on selects second frequency source, off the first
// - function 23 active while running forward stops forward running
// - function 24 active while running reverse stops reverse running
// - function 25 switches pump operation between hand and auto mode
// - hand mode: no PID, run and frequency from local controls
// - auto mode ignores jog requests
// - auto mode: only master controls; restarted slave follows master
// - contact-type bit n sets terminal n+1 normally closed
// - contact-type ignored for terminals 1-3 in external 2/3-wire mode
// - debounce delay is setting times 2 ms, setting 1 to 20
// - status active low, reads 63 with nothing active
// - select bit n set makes terminal n+1 internal, else external
// - action bit n drives internal terminal n+1 on
`timescale 1ns/10ps
`include "mic_consts.vh"
module mic_conditioner #(
   parameter NT       = 6,
   parameter UNIT_CYC = `MIC_DEB_UNIT_CYC
) (
   // clock and reset
   input  wire         clk,
   input  wire         reset_n,
   // terminal pins, active low
   input  wire [NT-1:0] term_pin_n,
   // parameter port
   input  wire         par_wr,
   input  wire [2:0]   par_addr,
   input  wire [11:0]  par_wdata,
   output reg  [11:0]  par_rdata_r,
   output reg          par_wr_refused_r,
   // function assignment, 5 bits per terminal
   input  wire [5*NT-1:0] term_func,
   // drive core context
   input  wire [1:0]   run_command_source_setting,
   input  wire         direction_restriction_setting,
   input  wire         first_frequency_source_setting,
   input  wire         running_fwd,
   input  wire         running_rev,
   input  wire         is_master_pump,
   input  wire         jog_req,
   input  wire         run_req,
   // requests to the drive core
   output reg          pid_disable_r,
   output reg          output_shutoff_r,
   output reg          restart_zero_r,
   output reg          param_lock_r,
   output reg  [1:0]   run_src_r,
   output reg          dir_override_r,
   output reg          dir_reverse_r,
   output reg          freq_src2_r,
   output reg          fwd_stop_r,
   output reg          rev_stop_r,
   output reg          hand_mode_r,
   output reg          jog_enable_r,
   output reg          local_control_r,
   output reg          slave_follow_r
);

   // --------------------------------------------------
   // parameter registers
   // --------------------------------------------------
   reg [11:0] contact_type_r;
   reg [4:0]  debounce_time_r;
   reg [11:0] int_ext_sel_r;
   reg [11:0] int_action_r;
   wire [NT-1:0] filt;
   reg  [NT-1:0] active;
   reg  [NT-1:0] status_n;
   wire [4:0] deb_clamped;

   // keep the debounce setting inside 1..20
   assign deb_clamped = (debounce_time_r < `MIC_DEBOUNCE_MIN) ? `MIC_DEBOUNCE_MIN :
                        (debounce_time_r > `MIC_DEBOUNCE_MAX) ? `MIC_DEBOUNCE_MAX :
                        debounce_time_r;

   // writes; all refused while the lock function is active
   always @(posedge clk) begin
      if (!reset_n) begin
         contact_type_r   <= `MIC_CONTACT_RST;
         debounce_time_r  <= `MIC_DEBOUNCE_RST;
         int_ext_sel_r    <= `MIC_INT_EXT_RST;
         int_action_r     <= `MIC_ACTION_RST;
         par_wr_refused_r <= 1'b0;
      end else begin
         par_wr_refused_r <= par_wr & param_lock_r;
         if (par_wr && !param_lock_r) begin
            case (par_addr)
               `MIC_REG_CONTACT_TYPE:  contact_type_r  <= par_wdata;
               `MIC_REG_DEBOUNCE_TIME: debounce_time_r <= par_wdata[4:0];
               `MIC_REG_INT_EXT_SEL:   int_ext_sel_r   <= par_wdata;
               `MIC_REG_INT_ACTION:    int_action_r    <= par_wdata;
               default: ;
            endcase
         end
      end
   end

   // read mux, registered
   always @(posedge clk) begin
      if (!reset_n) begin
         par_rdata_r <= 12'h000;
      end else begin
         case (par_addr)
            `MIC_REG_CONTACT_TYPE:  par_rdata_r <= contact_type_r;
            `MIC_REG_DEBOUNCE_TIME: par_rdata_r <= {7'h00, debounce_time_r};
            `MIC_REG_TERM_STATUS:   par_rdata_r <= {{(12-NT){1'b0}}, status_n};
            `MIC_REG_INT_EXT_SEL:   par_rdata_r <= int_ext_sel_r;
            `MIC_REG_INT_ACTION:    par_rdata_r <= int_action_r;
            default:                par_rdata_r <= 12'h000;
         endcase
      end
   end

   // --------------------------------------------------
   // debounce unit tick, one pulse each 2 ms
   // --------------------------------------------------
   reg [31:0] tick_cnt_r;
   reg        unit_tick_r;

   always @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt_r  <= 32'h0;
         unit_tick_r <= 1'b0;
      end else if (tick_cnt_r >= UNIT_CYC - 1) begin
         tick_cnt_r  <= 32'h0;
         unit_tick_r <= 1'b1;
      end else begin
         tick_cnt_r  <= tick_cnt_r + 32'h1;
         unit_tick_r <= 1'b0;
      end
   end

   // --------------------------------------------------
   // per-terminal synchroniser and debounce
   // --------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NT; g = g + 1) begin : g_term
         mic_debounce #(
            .CW (5)
         ) u_deb (
            .clk         (clk),
            .reset_n     (reset_n),
            .unit_tick   (unit_tick_r),
            .delay_units (deb_clamped),
            .raw_in      (term_pin_n[g]),
            .idle_level  (1'b1),
            .filt_r      (filt[g])
         );
      end
   endgenerate

   // --------------------------------------------------
   // polarity and internal/external selection
   // --------------------------------------------------
   wire ext_wire_mode;
   assign ext_wire_mode = (run_command_source_setting == `MIC_SRC_EXT_2WIRE) ||
                          (run_command_source_setting == `MIC_SRC_EXT_3WIRE);

   integer i;
   reg     nc;
   always @* begin
      nc = 1'b0;
      for (i = 0; i < NT; i = i + 1) begin
         nc = contact_type_r[i];
         if (ext_wire_mode && i < 3)
            nc = 1'b0;
         if (int_ext_sel_r[i])
            active[i] = int_action_r[i];
         else
            active[i] = (~filt[i]) ^ nc;
      end
   end

   // status word, active low
   always @(posedge clk) begin
      if (!reset_n)
         status_n <= `MIC_STATUS_IDLE;
      else
         status_n <= ~active;
   end

   // --------------------------------------------------
   // function decode
   // --------------------------------------------------
   reg f_pid, f_shut, f_lock, f_ext, f_key, f_comm, f_dir, f_frq, f_fwd, f_rev;
   reg f_hand_assigned, f_auto;
   reg a18, a19, a20;
   reg [4:0] fn;
   integer k;

   always @* begin
      f_pid = 1'b0; f_shut = 1'b0; f_lock = 1'b0; f_ext = 1'b0; f_key = 1'b0;
      f_comm = 1'b0; f_dir = 1'b0; f_frq = 1'b0; f_fwd = 1'b0; f_rev = 1'b0;
      f_hand_assigned = 1'b0; f_auto = 1'b0; a18 = 1'b0; a19 = 1'b0; a20 = 1'b0;
      fn = 5'h00;
      for (k = 0; k < NT; k = k + 1) begin
         fn = term_func[5*k +: 5];
         case (fn)
            `MIC_FN_PID_OFF:    f_pid  = f_pid  | active[k];
            `MIC_FN_SHUTOFF:    f_shut = f_shut | active[k];
            `MIC_FN_PARAM_LOCK: f_lock = f_lock | active[k];
            `MIC_FN_CMD_EXT: begin
               a18 = 1'b1;
               f_ext = f_ext | active[k];
            end
            `MIC_FN_CMD_KEYPAD: begin
               a19 = 1'b1;
               f_key = f_key | active[k];
            end
            `MIC_FN_CMD_COMM: begin
               a20 = 1'b1;
               f_comm = f_comm | active[k];
            end
            `MIC_FN_DIRECTION:  f_dir  = f_dir  | active[k];
            `MIC_FN_FREQ_SRC2:  f_frq  = f_frq  | active[k];
            `MIC_FN_FWD_LIMIT:  f_fwd  = f_fwd  | active[k];
            `MIC_FN_REV_LIMIT:  f_rev  = f_rev  | active[k];
            `MIC_FN_HAND_AUTO: begin
               f_hand_assigned = 1'b1;
               f_auto = f_auto | active[k];
            end
            default: ;
         endcase
      end
   end

   // --------------------------------------------------
   // request registers
   // --------------------------------------------------
   reg shut_prev_r;
   reg slave_stopped_r;
   wire hand;
   assign hand = f_hand_assigned & ~f_auto;

   always @(posedge clk) begin
      if (!reset_n) begin
         pid_disable_r    <= 1'b0;
         output_shutoff_r <= 1'b0;
         restart_zero_r   <= 1'b0;
         shut_prev_r      <= 1'b0;
         param_lock_r     <= 1'b0;
         run_src_r        <= `MIC_SRC_KEYPAD;
         dir_override_r   <= 1'b0;
         dir_reverse_r    <= 1'b0;
         freq_src2_r      <= 1'b0;
         fwd_stop_r       <= 1'b0;
         rev_stop_r       <= 1'b0;
         hand_mode_r      <= 1'b0;
         jog_enable_r     <= 1'b1;
         local_control_r  <= 1'b0;
         slave_follow_r   <= 1'b0;
         slave_stopped_r  <= 1'b0;
      end else begin
         pid_disable_r    <= f_pid | hand;
         shut_prev_r      <= f_shut;
         output_shutoff_r <= f_shut;
         restart_zero_r   <= shut_prev_r & ~f_shut;
         param_lock_r     <= f_lock;
         // command source override, terminal on wins
         if (a18 && f_ext)
            run_src_r <= `MIC_SRC_EXT_2WIRE;
         else if (a19 && f_key)
            run_src_r <= `MIC_SRC_KEYPAD;
         else if (a20 && f_comm)
            run_src_r <= `MIC_SRC_COMM;
         else
            run_src_r <= run_command_source_setting;
         dir_override_r   <= ~direction_restriction_setting;
         dir_reverse_r    <= f_dir & ~direction_restriction_setting;
         freq_src2_r      <= f_frq;
         fwd_stop_r       <= f_fwd & running_fwd;
         rev_stop_r       <= f_rev & running_rev;
         hand_mode_r      <= hand;
         local_control_r  <= hand;
         jog_enable_r     <= ~(f_hand_assigned & f_auto);
         // slave that was stopped and gets a run command follows master
         if (f_hand_assigned && f_auto && !is_master_pump) begin
            if (!run_req)
               slave_stopped_r <= 1'b1;
            else if (slave_stopped_r)
               slave_follow_r <= 1'b1;
         end else begin
            slave_stopped_r <= 1'b0;
            slave_follow_r  <= 1'b0;
         end
      end
   end

endmodule

// ==== mic_consts.vh ====
// constants for the multi-function input conditioner
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// register indices on the parameter port
`define MIC_REG_CONTACT_TYPE   3'h0
`define MIC_REG_DEBOUNCE_TIME  3'h1
`define MIC_REG_TERM_STATUS    3'h2
`define MIC_REG_INT_EXT_SEL    3'h3
`define MIC_REG_INT_ACTION     3'h4

// reset values
`define MIC_CONTACT_RST        12'h000
`define MIC_DEBOUNCE_RST       5'h01
`define MIC_INT_EXT_RST        12'h000
`define MIC_ACTION_RST         12'h000
`define MIC_STATUS_IDLE        6'h3F

// debounce setting limits
`define MIC_DEBOUNCE_MIN       5'h01
`define MIC_DEBOUNCE_MAX       5'h14

// terminal function codes
`define MIC_FN_PID_OFF         5'h0F
`define MIC_FN_SHUTOFF         5'h10
`define MIC_FN_PARAM_LOCK      5'h11
`define MIC_FN_CMD_EXT         5'h12
`define MIC_FN_CMD_KEYPAD      5'h13
`define MIC_FN_CMD_COMM        5'h14
`define MIC_FN_DIRECTION       5'h15
`define MIC_FN_FREQ_SRC2       5'h16
`define MIC_FN_FWD_LIMIT       5'h17
`define MIC_FN_REV_LIMIT       5'h18
`define MIC_FN_HAND_AUTO       5'h19

// run command sources
`define MIC_SRC_KEYPAD         2'h0
`define MIC_SRC_EXT_2WIRE      2'h1
`define MIC_SRC_EXT_3WIRE      2'h2
`define MIC_SRC_COMM           2'h3

// timing: debounce unit in microseconds, clock in kHz
`define MIC_DEB_UNIT_US        2000
`define MIC_CLK_KHZ            20000
`define MIC_DEB_UNIT_CYC       ((`MIC_DEB_UNIT_US * `MIC_CLK_KHZ) / 1000)

`endif

// ==== mic_debounce.v ====
// one terminal: synchroniser and stable-time debounce filter
`timescale 1ns/10ps
module mic_debounce #(
   parameter CW = 5
) (
   // clock and reset
   input  wire          clk,
   input  wire          reset_n,
   // tick and delay
   input  wire          unit_tick,
   input  wire [CW-1:0] delay_units,
   // raw and filtered level
   input  wire          raw_in,
   input  wire          idle_level,
   output reg           filt_r
);

   reg          sync1_r;
   reg          sync2_r;
   reg [CW-1:0] cnt_r;

   // --------------------------------------------------
   // two-stage synchroniser
   // --------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n) begin
         sync1_r <= idle_level;
         sync2_r <= idle_level;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   // --------------------------------------------------
   // stable-time filter
   // --------------------------------------------------
   // count whole units of agreement; any bounce restarts the count
   // one tick beyond the setting, so a partial first unit never shortens the delay
   always @(posedge clk) begin
      if (!reset_n) begin
         cnt_r  <= {CW{1'b0}};
         filt_r <= idle_level;
      end else if (sync2_r == filt_r) begin
         cnt_r <= {CW{1'b0}};
      end else if (unit_tick) begin
         if (cnt_r >= delay_units) begin
            filt_r <= sync2_r;
            cnt_r  <= {CW{1'b0}};
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

endmodule

// ==== mic_contacts.sv ====
// external contact model for the six input terminals
`timescale 1ns/10ps
module mic_contacts (
   // contact closures from the bench
   input  wire [5:0] press,
   // terminal pins, pulled up while the contact is open
   output wire [5:0] term_pin_n
);
   // closed contact pulls the pin low, open contact lets it float high
   assign term_pin_n = ~press;
endmodule

// ==== mic_conditioner_assertions.sv ====
// port checker for the input conditioner
`timescale 1ns/10ps
module mic_chk (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // parameter port
   input wire par_wr,
   input wire par_wr_refused_r,
   // drive context
   input wire running_fwd,
   input wire running_rev,
   input wire direction_restriction_setting,
   // requests
   input wire param_lock_r,
   input wire output_shutoff_r,
   input wire restart_zero_r,
   input wire hand_mode_r,
   input wire local_control_r,
   input wire pid_disable_r,
   input wire fwd_stop_r,
   input wire rev_stop_r,
   input wire dir_reverse_r
);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence lock_wr;
      par_wr && param_lock_r;
   endsequence
   sequence shut_end;
      $fell(output_shutoff_r);
   endsequence
   lock_refuse_a: assert property (lock_wr |=> par_wr_refused_r)
      else $error("locked write not refused");
   refuse_cause_a: assert property (par_wr_refused_r |-> $past(par_wr) && $past(param_lock_r))
      else $error("refusal without locked write");
   restart_seen_a: assert property (shut_end |-> ##[0:2] restart_zero_r)
      else $error("no restart after shutoff release");
   restart_pulse_a: assert property (restart_zero_r |=> !restart_zero_r)
      else $error("restart request longer than one cycle");
   hand_local_a: assert property (hand_mode_r == local_control_r)
      else $error("hand mode and local control differ");
   hand_pid_a: assert property (hand_mode_r |-> ##[0:2] pid_disable_r)
      else $error("hand mode without pid disabled");
   fwd_stop_a: assert property (fwd_stop_r |-> $past(running_fwd) || $past(running_fwd, 2))
      else $error("forward stop while not running forward");
   rev_stop_a: assert property (rev_stop_r |-> $past(running_rev) || $past(running_rev, 2))
      else $error("reverse stop while not running reverse");
   dir_allow_a: assert property (dir_reverse_r |->
      !$past(direction_restriction_setting) || !$past(direction_restriction_setting, 2))
      else $error("direction set while restricted");
endmodule
bind mic_conditioner mic_chk chk (.clk, .reset_n, .par_wr, .par_wr_refused_r, .running_fwd,
   .running_rev, .direction_restriction_setting, .param_lock_r, .output_shutoff_r,
   .restart_zero_r, .hand_mode_r, .local_control_r, .pid_disable_r, .fwd_stop_r, .rev_stop_r,
   .dir_reverse_r);

// ==== mic_tb.sv ====
// self-checking bench for the input conditioner
`timescale 1ns/10ps
module tb;
   // stimulus and observed signals
   reg         clk;
   reg         reset_n;
   reg         par_wr;
   reg  [2:0]  par_addr;
   reg  [11:0] par_wdata;
   reg  [29:0] term_func;
   reg  [1:0]  src;
   reg  [5:0]  press;
   wire [5:0]  pin_n;
   wire [11:0] rdata;
   wire        refused;
   wire        restart;
   wire [12:0] req;
   wire        slave;
   reg         restr;
   reg         fwd;
   reg         rev;
   reg         master;
   reg         run;
   integer     errors;
   integer     check_count;
   integer     cyc;
   integer     pulses;
   integer     f;
   // ----------------------------------------
   // design, contacts and clock
   // ----------------------------------------
   mic_contacts pins (.press(press), .term_pin_n(pin_n));
   mic_conditioner #(.UNIT_CYC(4)) uut (.clk(clk), .reset_n(reset_n), .term_pin_n(pin_n),
      .par_wr(par_wr), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata_r(rdata),
      .par_wr_refused_r(refused), .term_func(term_func), .run_command_source_setting(src),
      .direction_restriction_setting(restr), .first_frequency_source_setting(1'b0),
      .running_fwd(fwd), .running_rev(rev), .is_master_pump(master), .jog_req(1'b0),
      .run_req(run), .pid_disable_r(req[12]), .output_shutoff_r(req[11]),
      .restart_zero_r(restart), .param_lock_r(req[10]), .run_src_r(req[9:8]),
      .dir_override_r(req[7]), .dir_reverse_r(req[6]), .freq_src2_r(req[5]),
      .fwd_stop_r(req[4]), .rev_stop_r(req[3]), .hand_mode_r(req[2]),
      .jog_enable_r(req[1]), .local_control_r(req[0]), .slave_follow_r(slave));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // restart pulse count and hang limit
   always @(negedge clk) begin
      if (restart === 1'b1)
         pulses = pulses + 1;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         summarize;
      end
   end
   task summarize;
      begin
         $display("checks %0d errors %0d", check_count, errors);
         if (errors == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task check(input [12:0] seen, input [12:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [2:0] a, input [11:0] d);
      begin
         @(negedge clk);
         par_wr = 1'b1;
         par_addr = a;
         par_wdata = d;
         @(negedge clk);
         par_wr = 1'b0;
      end
   endtask
   task rd(input [2:0] a, input [11:0] e);
      begin
         @(negedge clk);
         par_addr = a;
         repeat (2) @(negedge clk);
         check({1'b0, rdata}, {1'b0, e});
      end
   endtask
   // expected requests: idle is 3-wire source, override allowed, jog on
   function [12:0] expv(input [4:0] fn, input on);
      begin
         expv = 13'h0282;
         if (on) case (fn)
            5'h0F: expv[12] = 1'b1;
            5'h10: expv[11] = 1'b1;
            5'h11: expv[10] = 1'b1;
            5'h12: expv[9:8] = 2'h1;
            5'h13: expv[9:8] = 2'h0;
            5'h14: expv[9:8] = 2'h3;
            5'h15: expv[6] = 1'b1;
            5'h16: expv[5] = 1'b1;
            5'h17: expv[4] = 1'b1;
            5'h18: expv[3] = 1'b1;
            default: expv[1] = 1'b0;
         endcase
         else if (fn == 5'h19)
            expv = expv | 13'h1005;
      end
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      begin
         rd(3'h0, 12'h000);
         rd(3'h1, 12'h001);
         rd(3'h2, 12'h03F);
         rd(3'h3, 12'h000);
         rd(3'h4, 12'h000);
         rd(3'h5, 12'h000);
         check(req, expv(5'h00, 1'b0));
      end
   endtask
   // every function code on internal terminal one, off then on
   task t_funcs;
      begin
         wr(3'h3, 12'h001);
         for (f = 15; f <= 25; f = f + 1) begin
            @(negedge clk);
            term_func[4:0] = f[4:0];
            repeat (4) @(negedge clk);
            check(req, expv(f[4:0], 1'b0));
            wr(3'h4, 12'h001);
            repeat (4) @(negedge clk);
            check(req, expv(f[4:0], 1'b1));
            rd(3'h2, 12'h03E);
            if (f == 17) begin
               wr(3'h1, 12'h005);
               check({12'h000, refused}, 13'h0001);
               rd(3'h1, 12'h001);
               term_func[4:0] = 5'h00;
            end
            wr(3'h4, 12'h000);
            repeat (4) @(negedge clk);
            term_func[4:0] = 5'h00;
         end
         check(pulses, 13'h0001);
      end
   endtask
   // short glitch dropped, held press seen after the programmed delay
   task t_debounce;
      begin
         wr(3'h3, 12'h000);
         wr(3'h1, 12'h002);
         press[3] = 1'b1;
         repeat (7) @(negedge clk);
         press[3] = 1'b0;
         repeat (20) @(negedge clk);
         rd(3'h2, 12'h03F);
         press[3] = 1'b1;
         repeat (4) @(negedge clk);
         rd(3'h2, 12'h03F);
         repeat (10) @(negedge clk);
         rd(3'h2, 12'h037);
         press[3] = 1'b0;
         repeat (20) @(negedge clk);
      end
   endtask
   // normally closed terminals, terminal one ignored in 2-wire mode
   task t_contact;
      begin
         src = 2'h1;
         wr(3'h0, 12'h009);
         repeat (24) @(negedge clk);
         rd(3'h2, 12'h037);
         rd(3'h0, 12'h009);
         src = 2'h0;
         rd(3'h2, 12'h036);
      end
   endtask
   // restriction, running state and pump role gate the requests
   task t_context;
      begin
         restr = 1'b1;
         fwd = 1'b0;
         rev = 1'b0;
         master = 1'b0;
         wr(3'h3, 12'h03F);
         term_func = {5'h00, 5'h00, 5'h18, 5'h17, 5'h15, 5'h19};
         wr(3'h4, 12'h00F);
         repeat (4) @(negedge clk);
         check(req, 13'h0200);
         check({12'h000, slave}, 13'h0000);
         run = 1'b1;
         repeat (2) @(negedge clk);
         check({12'h000, slave}, 13'h0001);
         restr = 1'b0;
         fwd = 1'b1;
         rev = 1'b1;
         master = 1'b1;
         repeat (3) @(negedge clk);
         check(req, 13'h02D8);
         check({12'h000, slave}, 13'h0000);
         run = 1'b0;
         wr(3'h4, 12'h000);
         term_func = 30'h0;
         repeat (4) @(negedge clk);
      end
   endtask
   initial begin
      errors = 0;
      check_count = 0;
      cyc = 0;
      pulses = 0;
      reset_n = 1'b0;
      par_wr = 1'b0;
      par_addr = 3'h0;
      par_wdata = 12'h000;
      term_func = 30'h0;
      src = 2'h2;
      press = 6'h00;
      restr = 1'b0;
      fwd = 1'b1;
      rev = 1'b1;
      master = 1'b1;
      run = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      t_reset;
      t_funcs;
      t_context;
      t_debounce;
      t_contact;
      summarize;
   end
endmodule
